// ==== logic/dof_defs.vh ====
// Constants for the dual converter output formatter
`ifndef DOF_DEFS_VH
`define DOF_DEFS_VH
// ************************************************************
// Register port
// ************************************************************
`define DOF_ADDR_W 2
`define DOF_ADDR_CLKPH 2'h2
`define DOF_ADDR_OMODE 2'h3
`define DOF_ADDR_STAT 2'h0
`define DOF_CLKPH_RST 8'h00
`define DOF_OMODE_RST 8'h00
`define DOF_CLKPH_DCS 0
`define DOF_OMODE_LO 0
`define DOF_OMODE_HI 1
`define DOF_OMODE_TERM 2
`define DOF_CUR_LO 4
`define DOF_CUR_HI 6
// ************************************************************
// Modes and drive codes
// ************************************************************
`define DOF_MODE_FULL 2'h0
`define DOF_MODE_DDR_SE 2'h1
`define DOF_MODE_DDR_DIFF 2'h2
`define DOF_CUR_DEFAULT 3'h0
// Drive current in units of 0.05 mA
`define DOF_I_3P5 8'h46
`define DOF_I_4P0 8'h50
`define DOF_I_4P5 8'h5A
`define DOF_I_1P75 8'h23
`define DOF_I_2P1 8'h2A
`define DOF_I_2P5 8'h32
`define DOF_I_3P0 8'h3C
// ************************************************************
// Timing
// ************************************************************
`define DOF_REF_HZ 20000000
`define DOF_NAP_HZ 500000
`define DOF_NAP_CYC (`DOF_REF_HZ / `DOF_NAP_HZ)
`define DOF_LOCK_CYC 100
`define DOF_CNT_W 8
`endif

// ==== logic/dof_formatter.v ====
// Output formatter for a two-channel sampling converter
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "dof_defs.vh"
module dof_formatter (
  input wire ref_clk,
  input wire rstn,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire par_mode,
  input wire par_dcs_pin,
  input wire par_mode_pin,
  input wire sample_clock_pos_input,
  input wire sample_clock_neg_input,
  input wire [11:0] chan_one_data,
  input wire [11:0] chan_two_data,
  input wire chan_one_out_of_range,
  input wire chan_two_out_of_range,
  input wire sample_valid,
  output wire sample_ready,
  output reg [11:0] chan_one_lines,
  output reg [11:0] chan_two_lines,
  output reg chan_one_overrange,
  output reg chan_two_overrange,
  output reg shared_overrange_line,
  output reg shared_overrange_neg,
  output reg [5:0] chan_one_bitpair_neg,
  output reg [5:0] chan_two_bitpair_neg,
  output reg forwarded_clock_pos,
  output reg forwarded_clock_neg,
  output reg nap,
  output reg single_ended_clock,
  output reg dcs_locked,
  output reg [1:0] out_mode,
  output reg [7:0] drive_current,
  output reg term_on
);
// ************************************************************
// Synchronisers
// ************************************************************
reg [1:0] pos_s;
reg [1:0] neg_s;
reg [1:0] pdcs_s;
reg [1:0] pmode_s;
reg [1:0] par_s;
reg pos_d;
always @(posedge ref_clk or negedge rstn) begin
  if (!rstn) begin
    pos_s <= 2'h0;
    // Idle high so reset does not fake a grounded negative input
    neg_s <= 2'h3;
    pdcs_s <= 2'h0;
    pmode_s <= 2'h0;
    par_s <= 2'h0;
    pos_d <= 1'b0;
  end else begin
    pos_s <= {pos_s[0], sample_clock_pos_input};
    neg_s <= {neg_s[0], sample_clock_neg_input};
    pdcs_s <= {pdcs_s[0], par_dcs_pin};
    pmode_s <= {pmode_s[0], par_mode_pin};
    par_s <= {par_s[0], par_mode};
    pos_d <= pos_s[1];
  end
end
wire clk_rise = pos_s[1] & ~pos_d;
wire clk_fall = ~pos_s[1] & pos_d;
// ************************************************************
// Registers
// ************************************************************
reg [7:0] clkph_reg;
reg [7:0] omode_reg;
always @(posedge ref_clk or negedge rstn) begin
  if (!rstn) begin
    clkph_reg <= `DOF_CLKPH_RST;
    omode_reg <= `DOF_OMODE_RST;
    reg_rdata <= 8'h00;
  end else begin
    if (reg_wr && reg_addr == `DOF_ADDR_CLKPH)
      clkph_reg <= reg_wdata;
    if (reg_wr && reg_addr == `DOF_ADDR_OMODE)
      omode_reg <= reg_wdata;
    if (reg_rd) begin
      case (reg_addr)
        `DOF_ADDR_CLKPH: reg_rdata <= clkph_reg;
        `DOF_ADDR_OMODE: reg_rdata <= omode_reg;
        `DOF_ADDR_STAT: reg_rdata <= {4'h0, dcs_locked,
          single_ended_clock, nap, term_on};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
end
// ************************************************************
// Configuration select
// ************************************************************
reg dcs_en;
reg [1:0] next_mode;
reg [2:0] cur_code;
reg term_req;
always @* begin
  if (par_s[1]) begin
    dcs_en = pdcs_s[1];
    // Pin strap reaches only full rate or DDR differential
    next_mode = pmode_s[1] ? `DOF_MODE_DDR_DIFF : `DOF_MODE_FULL;
    cur_code = `DOF_CUR_DEFAULT;
    term_req = 1'b0;
  end else begin
    dcs_en = clkph_reg[`DOF_CLKPH_DCS];
    next_mode = omode_reg[`DOF_OMODE_HI:`DOF_OMODE_LO];
    if (next_mode == 2'h3)
      next_mode = `DOF_MODE_FULL;
    cur_code = omode_reg[`DOF_CUR_HI:`DOF_CUR_LO];
    term_req = omode_reg[`DOF_OMODE_TERM];
  end
end
reg [7:0] next_current;
always @* begin
  case (cur_code)
    3'h0: next_current = `DOF_I_3P5;
    3'h1: next_current = `DOF_I_4P0;
    3'h2: next_current = `DOF_I_4P5;
    3'h4: next_current = `DOF_I_3P0;
    3'h5: next_current = `DOF_I_2P5;
    3'h6: next_current = `DOF_I_2P1;
    3'h7: next_current = `DOF_I_1P75;
    default: next_current = `DOF_I_3P5;
  endcase
  if (term_req)
    next_current = {next_current[6:0], 1'b0};
end
// ************************************************************
// Clock watch: nap, single-ended detect, stabilizer lock
// ************************************************************
reg [`DOF_CNT_W-1:0] gap_cnt;
reg [`DOF_CNT_W-1:0] lock_cnt;
reg [`DOF_CNT_W-1:0] per_cnt;
reg [`DOF_CNT_W-1:0] last_per;
always @(posedge ref_clk or negedge rstn) begin
  if (!rstn) begin
    gap_cnt <= {`DOF_CNT_W{1'b0}};
    lock_cnt <= {`DOF_CNT_W{1'b0}};
    per_cnt <= {`DOF_CNT_W{1'b0}};
    last_per <= {`DOF_CNT_W{1'b0}};
    nap <= 1'b1;
    single_ended_clock <= 1'b0;
    dcs_locked <= 1'b0;
    out_mode <= `DOF_MODE_FULL;
    drive_current <= `DOF_I_3P5;
    term_on <= 1'b0;
  end else begin
    out_mode <= next_mode;
    drive_current <= next_current;
    term_on <= term_req;
    // Logic low on the negative input stands for near ground
    single_ended_clock <= ~neg_s[1];
    if (clk_rise) begin
      gap_cnt <= {`DOF_CNT_W{1'b0}};
      nap <= 1'b0;
    end else if (gap_cnt >= `DOF_NAP_CYC) begin
      nap <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 1'b1;
    end
    if (clk_rise) begin
      per_cnt <= {`DOF_CNT_W{1'b0}};
      last_per <= per_cnt;
    end else if (per_cnt != {`DOF_CNT_W{1'b1}}) begin
      per_cnt <= per_cnt + 1'b1;
    end
    // Period change of more than one tick restarts lock
    if (!dcs_en || nap) begin
      lock_cnt <= {`DOF_CNT_W{1'b0}};
      dcs_locked <= 1'b0;
    end else if (clk_rise) begin
      if (per_cnt > last_per + 1'b1 || per_cnt + 1'b1 < last_per) begin
        lock_cnt <= {`DOF_CNT_W{1'b0}};
        dcs_locked <= 1'b0;
      end else if (lock_cnt >= `DOF_LOCK_CYC - 1) begin
        dcs_locked <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 1'b1;
      end
    end
  end
end
// Stabilizer: output clock half phase from measured period,
// so 30..70 percent input duty still gives 50 percent out
wire half_hit = dcs_en && per_cnt == {1'b0, last_per[`DOF_CNT_W-1:1]};
// ************************************************************
// Two-entry sample buffer
// ************************************************************
reg [25:0] buf_mem [0:1];
reg wp;
reg rp;
reg [1:0] fill;
reg ready_q;
wire take = clk_rise && !nap && fill != 2'h0;
wire [1:0] next_fill = fill + {1'b0, sample_valid && sample_ready} -
  {1'b0, take};
// Ready is registered from the next fill, so it still leaves a flop
assign sample_ready = ready_q;
always @(posedge ref_clk or negedge rstn) begin
  if (!rstn) begin
    wp <= 1'b0;
    rp <= 1'b0;
    fill <= 2'h0;
    ready_q <= 1'b1;
  end else begin
    if (sample_valid && sample_ready) begin
      // Flags ride with the data so latency matches
      buf_mem[wp] <= {chan_two_out_of_range, chan_one_out_of_range,
        chan_two_data, chan_one_data};
      wp <= ~wp;
    end
    if (take)
      rp <= ~rp;
    fill <= next_fill;
    ready_q <= next_fill != 2'h2;
  end
end
// ************************************************************
// Output formatting
// ************************************************************
reg [25:0] cur;
reg phase;
always @(posedge ref_clk or negedge rstn) begin
  if (!rstn) begin
    cur <= 26'h0;
    phase <= 1'b0;
  end else if (nap) begin
    phase <= 1'b0;
  end else begin
    if (take)
      cur <= buf_mem[rp];
    if (clk_rise)
      phase <= 1'b0;
    else if (dcs_en ? half_hit : clk_fall)
      phase <= 1'b1;
  end
end
integer i;
reg [5:0] one_pair;
reg [5:0] two_pair;
reg ovr_mux;
always @* begin
  one_pair = 6'h0;
  two_pair = 6'h0;
  for (i = 0; i < 6; i = i + 1) begin
    one_pair[i] = phase ? cur[2*i+1] : cur[2*i];
    two_pair[i] = phase ? cur[12+2*i+1] : cur[12+2*i];
  end
  ovr_mux = phase ? cur[24] : cur[25];
end
// Outputs change on clock edges: forwarded clock high = odd phase
always @(posedge ref_clk or negedge rstn) begin
  if (!rstn) begin
    chan_one_lines <= 12'h000;
    chan_two_lines <= 12'h000;
    chan_one_overrange <= 1'b0;
    chan_two_overrange <= 1'b0;
    shared_overrange_line <= 1'b0;
    shared_overrange_neg <= 1'b1;
    chan_one_bitpair_neg <= 6'h3F;
    chan_two_bitpair_neg <= 6'h3F;
    forwarded_clock_pos <= 1'b0;
    forwarded_clock_neg <= 1'b1;
  end else begin
    forwarded_clock_pos <= phase;
    forwarded_clock_neg <= ~phase;
    chan_one_lines <= 12'h000;
    chan_two_lines <= 12'h000;
    chan_one_overrange <= 1'b0;
    chan_two_overrange <= 1'b0;
    shared_overrange_line <= 1'b0;
    shared_overrange_neg <= 1'b1;
    chan_one_bitpair_neg <= 6'h3F;
    chan_two_bitpair_neg <= 6'h3F;
    case (out_mode)
      `DOF_MODE_FULL: begin
        chan_one_lines <= cur[11:0];
        chan_two_lines <= cur[23:12];
        chan_one_overrange <= cur[24];
        chan_two_overrange <= cur[25];
      end
      `DOF_MODE_DDR_SE: begin
        chan_one_lines <= {6'h00, one_pair};
        chan_two_lines <= {6'h00, two_pair};
        shared_overrange_line <= ovr_mux;
      end
      `DOF_MODE_DDR_DIFF: begin
        chan_one_lines <= {6'h00, one_pair};
        chan_two_lines <= {6'h00, two_pair};
        chan_one_bitpair_neg <= ~one_pair;
        chan_two_bitpair_neg <= ~two_pair;
        shared_overrange_line <= ovr_mux;
        shared_overrange_neg <= ~ovr_mux;
      end
      default: begin
        chan_one_lines <= 12'h000;
      end
    endcase
  end
end
endmodule // dof_formatter
`default_nettype wire

// ==== testbench/dof_formatter_assertions.sv ====
// Concurrent checks on the formatter's pins
`timescale 1ns/100ps
`default_nettype none
`include "dof_defs.vh"
module dof_formatter_assertions (
  input wire ref_clk,
  input wire rstn,
  input wire par_mode,
  input wire sample_clock_pos_input,
  input wire sample_clock_neg_input,
  input wire [11:0] chan_one_lines,
  input wire [11:0] chan_two_lines,
  input wire [5:0] chan_two_bitpair_neg,
  input wire chan_one_overrange,
  input wire chan_two_overrange,
  input wire shared_overrange_line,
  input wire shared_overrange_neg,
  input wire [5:0] chan_one_bitpair_neg,
  input wire forwarded_clock_pos,
  input wire forwarded_clock_neg,
  input wire nap,
  input wire single_ended_clock,
  input wire [1:0] out_mode,
  input wire [7:0] drive_current,
  input wire term_on
);
  // Cycles since the sample clock last moved; saturates
  logic [6:0] still_cnt;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) still_cnt <= 7'h00;
    else if ($changed(sample_clock_pos_input)) still_cnt <= 7'h00;
    else if (still_cnt != 7'h7F) still_cnt <= still_cnt + 7'h01;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  nap_set_a: assert property (still_cnt == 7'h3C |-> nap)
    else $error("No nap after clock stop");
  nap_clear_a: assert property (
    $rose(sample_clock_pos_input) |-> ##[1:8] !nap)
    else $error("Nap kept with clock running");
  clk_pair_a: assert property (
    forwarded_clock_neg == !forwarded_clock_pos)
    else $error("Clock pair not complementary");
  diff_pair2_a: assert property (
    out_mode == `DOF_MODE_DDR_DIFF && $stable(out_mode) |->
    chan_two_bitpair_neg == ~chan_two_lines[5:0] &&
    chan_two_lines[11:6] == 6'h00)
    else $error("Second channel pair not complementary");
  diff_pair_a: assert property (
    out_mode == `DOF_MODE_DDR_DIFF && $stable(out_mode) |->
    chan_one_bitpair_neg == ~chan_one_lines[5:0] &&
    shared_overrange_neg == !shared_overrange_line)
    else $error("Data pair not complementary");
  ddr_lines_a: assert property (
    out_mode != `DOF_MODE_FULL && $stable(out_mode) |->
    chan_one_lines[11:6] == 6'h00 && !chan_one_overrange &&
    !chan_two_overrange)
    else $error("Full rate pins active in DDR");
  term_cur_a: assert property (term_on |-> drive_current inside
    {8'h46, 8'h54, 8'h64, 8'h78, 8'h8C, 8'hA0, 8'hB4})
    else $error("Current not doubled");
  se_clock_a: assert property (
    $fell(sample_clock_neg_input) |-> ##[1:5] single_ended_clock)
    else $error("Single-ended clock not detected");
  pin_strap_a: assert property (
    par_mode [*6] |-> out_mode != `DOF_MODE_DDR_SE)
    else $error("Pin strap reached DDR single-ended");
endmodule // dof_formatter_assertions
bind dof_formatter dof_formatter_assertions chk_u (.*);
`default_nettype wire

// ==== testbench/dof_capture_model.sv ====
// Capture receiver model on the far side of the output lines
`timescale 1ns/100ps
`default_nettype none
module dof_capture_model (
  input wire logic ref_clk,
  input wire logic ddr,
  input wire logic clk_pos,
  input wire logic [11:0] lines_one,
  input wire logic [11:0] lines_two,
  input wire logic of_one,
  input wire logic of_two,
  input wire logic of_shared,
  output logic [25:0] word,
  output logic word_stb
);
  // Sampled on the system clock, since data and forwarded clock
  // launch at one edge and would race a forwarded-clock capture
  logic pos_q;
  logic [12:0] lo_q;
  logic [26:0] hi_q;
  function automatic logic [11:0] mix(input logic [5:0] ev, od);
    for (int i = 0; i < 6; i++) mix[2 * i +: 2] = {od[i], ev[i]};
  endfunction
  always @(posedge ref_clk) begin
    pos_q <= clk_pos;
    word_stb <= pos_q & ~clk_pos;
    if (!clk_pos) lo_q <= {of_shared, lines_two[5:0], lines_one[5:0]};
    else hi_q <= {of_shared, of_one, of_two, lines_one, lines_two};
    if (pos_q & ~clk_pos) word <= ddr ? {hi_q[26], lo_q[12],
      mix(lo_q[5:0], hi_q[17:12]), mix(lo_q[11:6], hi_q[5:0])} : hi_q[25:0];
  end
endmodule // dof_capture_model
`default_nettype wire

// ==== testbench/tb_dof_formatter.sv ====
// Self-checking bench for the dual converter output formatter
`timescale 1ns/100ps
`default_nettype none
module tb_dof_formatter;
  logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic par_mode = 1'b0, par_dcs_pin = 1'b0, par_mode_pin = 1'b0;
  logic sample_clock_pos_input = 1'b0, sample_clock_neg_input = 1'b1;
  logic chan_one_out_of_range = 1'b0, chan_two_out_of_range = 1'b0;
  logic sample_valid = 1'b0, run = 1'b1, ddr_sel = 1'b0, word_stb;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, d;
  logic [11:0] chan_one_data = 12'h000, chan_two_data = 12'h000;
  logic [25:0] word, last_w = 26'h0000000;
  logic [25:0] exp_q [$];
  wire logic [7:0] reg_rdata, drive_current;
  wire logic [11:0] chan_one_lines, chan_two_lines;
  wire logic [5:0] chan_one_bitpair_neg, chan_two_bitpair_neg;
  wire logic [1:0] out_mode;
  wire logic sample_ready, chan_one_overrange, chan_two_overrange, nap;
  wire logic shared_overrange_line, shared_overrange_neg, term_on;
  wire logic forwarded_clock_pos, forwarded_clock_neg, dcs_locked;
  wire logic single_ended_clock;
  int fail_count = 0, checked = 0, hp = 200;
  // Rows: mode register write, mode, drive current, termination
  logic [31:0] rows [8] = '{32'h00004600, 32'h11015000, 32'h22025A00,
    32'h33004600, 32'h42023C00, 32'h52023200, 32'h62022A00, 32'h76024601};
  dof_formatter dut_u (.*);
  dof_capture_model rx_u (.ref_clk(ref_clk), .ddr(ddr_sel),
    .clk_pos(forwarded_clock_pos), .lines_one(chan_one_lines),
    .lines_two(chan_two_lines), .of_one(chan_one_overrange),
    .of_two(chan_two_overrange), .of_shared(shared_overrange_line),
    .word(word), .word_stb(word_stb));
  always #25 ref_clk = ~ref_clk;
  // Stops low when halted, like a gated encode source
  always #(hp) sample_clock_pos_input = run & ~sample_clock_pos_input;
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  // Valid stays up between pushes; the caller drops it
  task automatic push(input logic [25:0] w);
    int n;
    n = 0;
    {chan_one_out_of_range, chan_two_out_of_range, chan_one_data,
      chan_two_data} <= w;
    sample_valid <= 1'b1;
    @(negedge ref_clk);
    while (sample_ready !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 3000) fail_count++;
    @(posedge ref_clk);
    exp_q.push_back(w);
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // A repeat of the held word is ignored; anything else must be next
  always @(posedge ref_clk) begin
    if (word_stb === 1'b1) begin
      if (exp_q.size() == 0) last_w = word;
      else if (word === exp_q[0] || word !== last_w) begin
        chk(word, exp_q[0]);
        last_w = exp_q.pop_front();
      end
    end
  end
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk(drive_current, 8'h46);
    @(posedge ref_clk);
    wr(2'h1, 8'hFF);
    rd(2'h1, d);
    chk(d, 0);
    foreach (rows[i]) begin
      ddr_sel = rows[i][23:16] != 8'h00;
      wr(2'h3, rows[i][31:24]);
      @(negedge ref_clk);
      chk(out_mode, rows[i][23:16]);
      chk(drive_current, rows[i][15:8]);
      chk(term_on, rows[i][7:0]);
      @(posedge ref_clk);
      rd(2'h3, d);
      chk(d, rows[i][31:24]);
      repeat (30) @(posedge ref_clk);
      for (int k = 0; k < 3; k++)
        push({k[0], !k[0], 12'(i * 37 + k * 5 + 1), 12'(~(i * 37 + k))});
      sample_valid <= 1'b0;
      repeat (40) @(posedge ref_clk);
    end
    run = 1'b0;
    repeat (80) @(posedge ref_clk);
    push(26'h2A5A5A5);
    push(26'h15A5A5A);
    @(negedge ref_clk);
    chk(nap, 1);
    chk(sample_ready, 0);
    run = 1'b1;
    sample_valid <= 1'b0;
    repeat (60) @(negedge ref_clk);
    chk(nap, 0);
    chk(exp_q.size(), 0);
    chk(single_ended_clock, 0);
    @(posedge ref_clk);
    sample_clock_neg_input <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(single_ended_clock, 1);
    @(posedge ref_clk);
    sample_clock_neg_input <= 1'b1;
    hp = 100;
    wr(2'h2, 8'h01);
    repeat (200) @(negedge ref_clk);
    chk(dcs_locked, 0);
    repeat (240) @(posedge ref_clk);
    rd(2'h0, d);
    chk(d[3], 1);
    wr(2'h3, 8'h01);
    par_mode <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(out_mode, 0);
    chk(dcs_locked, 0);
    @(posedge ref_clk);
    par_mode_pin <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(out_mode, 2);
    chk(drive_current, 8'h46);
    // Reset in mid-run: no false single-ended or clock edge after it
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(nap, 1);
    chk(single_ended_clock, 0);
    end_of_test();
  end
endmodule // tb_dof_formatter
`default_nettype wire
